// ===== design/image_accel_launch_checker_map.svh
`ifndef IMAGE_ACCEL_LAUNCH_CHECKER_MAP_SVH
`define IMAGE_ACCEL_LAUNCH_CHECKER_MAP_SVH

// foreground / background pixel format codes
`define FMT_ARGB8888 4'h0
`define FMT_RGB888   4'h1
`define FMT_RGB565   4'h2
`define FMT_ARGB1555 4'h3
`define FMT_ARGB4444 4'h4
`define FMT_L8       4'h5
`define FMT_AL44     4'h6
`define FMT_AL88     4'h7
`define FMT_L4       4'h8
`define FMT_A8       4'h9
`define FMT_A4       4'hA
`define FMT_UYVY422  4'hB
`define FMT_VYUY422  4'hC
`define FMT_YUV422SP 4'hD
`define FMT_YUV420   4'hE
`define FMT_YVU420   4'hF

// destination pixel format codes
`define DST_ARGB8888 3'h0
`define DST_RGB565   3'h2
`define DST_ARGB1555 3'h3
`define DST_ARGB4444 3'h4

// format code limits
`define FG_COPY_MAX  4'hD
`define BG_FMT_MAX   4'hA
`define DST_FMT_MAX  3'h4

// scale factor range and defaults
`define SCALE_LIMIT  14'h2001
`define SCALE_DEF    14'h1000
`define DEC_DEF      2'h0
`define TURN_DEF     2'h0

// per-mode masks over the eighteen checks (bit n = check n+1)
`define CHK_COUNT    18
`define MASK_COPY    18'h01B13
`define MASK_CONVERT 18'h0FAD3
`define MASK_BLEND   18'h3FEFF
`define MASK_FILL    18'h018C0

`endif

// ===== design/image_accel_launch_checker_pkg.sv
`default_nettype none
package image_accel_launch_checker_pkg;

  typedef enum logic [1:0] {
    MODE_COPY,
    MODE_CONVERT,
    MODE_BLEND,
    MODE_FILL
  } convMode_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_FG_LUT,
    OP_BG_LUT,
    OP_XFER
  } opState_t;

  typedef struct packed {
    logic [31:0] base;
    logic        fmtBit;
  } lutCfg_t;

  typedef struct packed {
    logic [31:0] base;
    logic [3:0]  fmt;
    logic [15:0] lineGap;
    logic        extraPlane;
    logic [31:0] chromaBase;
  } fgCfg_t;

  typedef struct packed {
    logic [31:0] base;
    logic [3:0]  fmt;
    logic [15:0] lineGap;
  } bgCfg_t;

  typedef struct packed {
    logic [31:0] base;
    logic [2:0]  fmt;
    logic [15:0] lineGap;
  } dstCfg_t;

  typedef struct packed {
    logic [15:0] cols;
    logic [15:0] rows;
    logic [15:0] outCols;
    logic [15:0] outRows;
  } sizeCfg_t;

  typedef struct packed {
    logic [13:0] xRecip;
    logic [13:0] yRecip;
    logic [1:0]  hDec;
    logic [1:0]  vDec;
    logic [1:0]  turn;
  } scaleCfg_t;

  typedef struct packed {
    logic fgLut;
    logic bgLut;
    logic xfer;
  } launch_t;

endpackage
`default_nettype wire

// ===== design/image_accel_launch_checker.sv
`include "image_accel_launch_checker_map.svh"
`default_nettype none
module image_accel_launch_checker (
  input  wire logic                                  clock,
  input  wire logic                                  reset_n,
  input  wire logic                                  fgLutLoadReq,
  input  wire logic                                  bgLutLoadReq,
  input  wire logic                                  transferReq,
  input  wire logic                                  stopReq,
  input  wire logic                                  clearBadConfig,
  input  wire logic                                  fgLutDone,
  input  wire logic                                  bgLutDone,
  input  wire logic                                  transferDone,
  input  wire image_accel_launch_checker_pkg::convMode_t conversion_mode,
  input  wire image_accel_launch_checker_pkg::lutCfg_t   fgLutCfg,
  input  wire image_accel_launch_checker_pkg::lutCfg_t   bgLutCfg,
  input  wire image_accel_launch_checker_pkg::fgCfg_t    fgCfg,
  input  wire image_accel_launch_checker_pkg::bgCfg_t    bgCfg,
  input  wire image_accel_launch_checker_pkg::dstCfg_t   dstCfg,
  input  wire image_accel_launch_checker_pkg::sizeCfg_t  sizeCfg,
  input  wire image_accel_launch_checker_pkg::scaleCfg_t scaleCfg,
  output logic                                       transfer_go_q,
  output logic                                       fg_lut_load_go_q,
  output logic                                       bg_lut_load_go_q,
  output logic                                       stop_request_q,
  output logic                                       bad_config_flag_q,
  output logic                                       rejectPulse_q,
  output image_accel_launch_checker_pkg::launch_t    launch_q,
  output logic [`CHK_COUNT-1:0]                      failedChecks_q
);
  import image_accel_launch_checker_pkg::*;

  function automatic logic isA4L4(input logic [3:0] f);
    return (f == `FMT_A4) || (f == `FMT_L4);
  endfunction

  function automatic logic isPacked422(input logic [3:0] f);
    return (f == `FMT_UYVY422) || (f == `FMT_VYUY422);
  endfunction

  function automatic logic is420(input logic [3:0] f);
    return (f == `FMT_YUV420) || (f == `FMT_YVU420);
  endfunction

  function automatic logic isHalfFmt(input logic [3:0] f);
    return (f == `FMT_RGB565) || (f == `FMT_ARGB1555) ||
           (f == `FMT_ARGB4444) || (f == `FMT_AL88);
  endfunction

  // alignment fault of an address for word or halfword formats
  function automatic logic misaligned(input logic [31:0] a,
                                      input logic        wordFmt,
                                      input logic        halfFmt);
    return (wordFmt && (a[1:0] != 2'h0)) || (halfFmt && a[0]);
  endfunction

  function automatic logic [`CHK_COUNT-1:0] modeMask(input convMode_t m);
    case (m)
      MODE_COPY:    return `MASK_COPY;
      MODE_CONVERT: return `MASK_CONVERT;
      MODE_BLEND:   return `MASK_BLEND;
      MODE_FILL:    return `MASK_FILL;
      default:      return `MASK_BLEND;
    endcase
  endfunction

  opState_t              opState_q;
  logic [`CHK_COUNT-1:0] chk;
  logic [`CHK_COUNT-1:0] chkApplied;
  logic                  fgWord;
  logic                  scalingOn;
  logic                  rotationOn;
  logic                  idle;
  logic                  fgLutTake;
  logic                  bgLutTake;
  logic                  xferTake;
  logic                  fgLutBad;
  logic                  bgLutBad;
  logic                  xferBad;
  logic                  anyTake;
  logic                  takeBad;
  logic                  stopTake;

  always_comb
  begin
    fgWord     = (fgCfg.fmt == `FMT_ARGB8888) || isPacked422(fgCfg.fmt) ||
                 is420(fgCfg.fmt);
    scalingOn  = (scaleCfg.hDec != `DEC_DEF) || (scaleCfg.vDec != `DEC_DEF) ||
                 (scaleCfg.xRecip != `SCALE_DEF) ||
                 (scaleCfg.yRecip != `SCALE_DEF);
    rotationOn = scaleCfg.turn != `TURN_DEF;
    chk[0]  = misaligned(fgCfg.base, fgWord, isHalfFmt(fgCfg.fmt));
    chk[1]  = ((isA4L4(fgCfg.fmt) || isPacked422(fgCfg.fmt)) &&
               fgCfg.lineGap[0]) ||
              (is420(fgCfg.fmt) && (fgCfg.lineGap[1:0] != 2'h0));
    chk[2]  = misaligned(bgCfg.base, bgCfg.fmt == `FMT_ARGB8888,
                         isHalfFmt(bgCfg.fmt));
    chk[3]  = isA4L4(bgCfg.fmt) && bgCfg.lineGap[0];
    // a 4-bit code cannot pass 0xF, so only the copy limit can fail
    chk[4]  = (conversion_mode == MODE_COPY) &&
              (fgCfg.fmt > `FG_COPY_MAX);
    chk[5]  = bgCfg.fmt > `BG_FMT_MAX;
    chk[6]  = dstCfg.fmt > `DST_FMT_MAX;
    chk[7]  = misaligned(dstCfg.base, dstCfg.fmt == `DST_ARGB8888,
                         (dstCfg.fmt == `DST_RGB565) ||
                         (dstCfg.fmt == `DST_ARGB1555) ||
                         (dstCfg.fmt == `DST_ARGB4444));
    chk[8]  = isA4L4(fgCfg.fmt) && dstCfg.lineGap[0];
    chk[9]  = ((isA4L4(fgCfg.fmt) || isPacked422(fgCfg.fmt)) &&
               sizeCfg.cols[0]) ||
              (is420(fgCfg.fmt) && (sizeCfg.cols[1:0] != 2'h0));
    chk[10] = isA4L4(bgCfg.fmt) && sizeCfg.cols[0];
    chk[11] = sizeCfg.cols == 16'h0000;
    chk[12] = sizeCfg.rows == 16'h0000;
    chk[13] = (scaleCfg.xRecip == 14'h0000) ||
              (scaleCfg.xRecip >= `SCALE_LIMIT) ||
              (scaleCfg.yRecip == 14'h0000) ||
              (scaleCfg.yRecip >= `SCALE_LIMIT);
    chk[14] = fgCfg.extraPlane &&
              (is420(fgCfg.fmt) ||
               misaligned(fgCfg.chromaBase,
                          (fgCfg.fmt == `FMT_ARGB8888) ||
                          isPacked422(fgCfg.fmt),
                          isHalfFmt(fgCfg.fmt)));
    chk[15] = is420(fgCfg.fmt) && fgCfg.chromaBase[0];
    chk[16] = scalingOn && isA4L4(bgCfg.fmt) && sizeCfg.outCols[0];
    chk[17] = scalingOn && rotationOn && isA4L4(bgCfg.fmt) &&
              sizeCfg.outRows[0];
  end

  // mode decides which checks count
  assign chkApplied = chk & modeMask(conversion_mode);

  // only one operation at a time; requests while busy are dropped
  assign idle      = opState_q == OP_NONE;
  assign fgLutTake = idle && fgLutLoadReq;
  assign bgLutTake = idle && bgLutLoadReq && !fgLutLoadReq;
  assign xferTake  = idle && transferReq && !fgLutLoadReq && !bgLutLoadReq;
  assign fgLutBad  = !fgLutCfg.fmtBit && (fgLutCfg.base[1:0] != 2'h0);
  assign bgLutBad  = !bgLutCfg.fmtBit && (bgLutCfg.base[1:0] != 2'h0);
  assign xferBad   = |chkApplied;
  assign anyTake   = fgLutTake || bgLutTake || xferTake;
  assign takeBad   = (fgLutTake && fgLutBad) || (bgLutTake && bgLutBad) ||
                     (xferTake && xferBad);
  assign stopTake  = stopReq && !idle;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      opState_q <= OP_NONE;
    else
    begin
      case (opState_q)
        OP_NONE:
        begin
          if (fgLutTake && !fgLutBad)
            opState_q <= OP_FG_LUT;
          else if (bgLutTake && !bgLutBad)
            opState_q <= OP_BG_LUT;
          else if (xferTake && !xferBad)
            opState_q <= OP_XFER;
        end
        OP_FG_LUT:
          if (stopReq || fgLutDone)
            opState_q <= OP_NONE;
        OP_BG_LUT:
          if (stopReq || bgLutDone)
            opState_q <= OP_NONE;
        OP_XFER:
          if (stopReq || transferDone)
            opState_q <= OP_NONE;
        default:
          opState_q <= OP_NONE;
      endcase
    end
  end

  // start bits are set only after the checks have passed
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      fg_lut_load_go_q <= 1'b0;
      bg_lut_load_go_q <= 1'b0;
      transfer_go_q    <= 1'b0;
    end
    else
    begin
      fg_lut_load_go_q <= (fgLutTake && !fgLutBad) ||
                          (fg_lut_load_go_q && !stopReq && !fgLutDone);
      bg_lut_load_go_q <= (bgLutTake && !bgLutBad) ||
                          (bg_lut_load_go_q && !stopReq && !bgLutDone);
      transfer_go_q    <= (xferTake && !xferBad) ||
                          (transfer_go_q && !stopReq && !transferDone);
    end
  end

  // launch strobes to the bus master only for clean configurations
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      launch_q <= '0;
    else
    begin
      launch_q.fgLut <= fgLutTake && !fgLutBad;
      launch_q.bgLut <= bgLutTake && !bgLutBad;
      launch_q.xfer  <= xferTake && !xferBad;
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      bad_config_flag_q <= 1'b0;
      rejectPulse_q     <= 1'b0;
    end
    else
    begin
      rejectPulse_q     <= takeBad;
      bad_config_flag_q <= takeBad || (bad_config_flag_q && !clearBadConfig);
    end
  end

  // keeps the reason for the most recent rejected transfer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      failedChecks_q <= '0;
    else if (xferTake && xferBad)
      failedChecks_q <= chkApplied;
  end

  // stop bit reads one for the cycle after a stop taken while busy, never for a stop made while idle
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      stop_request_q <= 1'b0;
    else
      stop_request_q <= stopTake;
  end

  rejectNoLaunch_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    rejectPulse_q |-> (launch_q == '0))
    else $error("launch issued for a rejected operation");

  badXferClears_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && xferBad) |=> (!transfer_go_q && bad_config_flag_q))
    else $error("bad transfer not cancelled and flagged");

  lutAlign_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (fgLutTake && !fgLutCfg.fmtBit && fgLutCfg.base[0]) |=>
      (rejectPulse_q && !fg_lut_load_go_q))
    else $error("misaligned LUT base accepted");

  zeroSize_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && (sizeCfg.rows == 16'h0000)) |=> rejectPulse_q)
    else $error("zero height accepted");

  scaleRange_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && (conversion_mode == MODE_BLEND) &&
     (scaleCfg.xRecip == `SCALE_LIMIT)) |=> !launch_q.xfer)
    else $error("out of range scale factor accepted");

  copyFmt_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && (conversion_mode == MODE_COPY) &&
     (fgCfg.fmt == `FMT_YUV420)) |=> failedChecks_q[4])
    else $error("copy mode format limit not enforced");

  copyGap_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && (conversion_mode == MODE_COPY) &&
     (fgCfg.fmt == `FMT_YUV420) && (fgCfg.lineGap[1:0] != 2'h0)) |=>
      failedChecks_q[1])
    else $error("copy mode line gap check not applied");

  fillIgnoresFg_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && (conversion_mode == MODE_FILL) && !chk[6] && !chk[7] &&
     !chk[11] && !chk[12]) |=> (launch_q.xfer && transfer_go_q))
    else $error("fill mode rejected on an unused check");

  dstFmt_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (xferTake && (conversion_mode == MODE_CONVERT) &&
     (dstCfg.fmt > `DST_FMT_MAX)) |=> (rejectPulse_q && failedChecks_q[6]))
    else $error("bad destination format accepted");

  stopIdle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (stopReq && idle) |=> !stop_request_q)
    else $error("stop bit set while idle");

  stopClears_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    stopTake |=> (stop_request_q && !transfer_go_q && !fg_lut_load_go_q &&
                  !bg_lut_load_go_q))
    else $error("stop did not end the running operation");

  oneGo_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $onehot0({fg_lut_load_go_q, bg_lut_load_go_q, transfer_go_q}))
    else $error("more than one operation running");

  takeAnswer_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    anyTake |=> ((launch_q != '0) != rejectPulse_q))
    else $error("start request without exactly one answer");

  flagHold_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (bad_config_flag_q && !clearBadConfig) |=> bad_config_flag_q)
    else $error("bad config flag lost");

  flagSetWins_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (takeBad && clearBadConfig) |=> bad_config_flag_q)
    else $error("clear beat a new configuration fault");

  xferLaunch_c: cover property (@(posedge clock) disable iff (!reset_n)
    xferTake && !xferBad ##1 launch_q.xfer ##[1:20] !transfer_go_q);
  xferReject_c: cover property (@(posedge clock) disable iff (!reset_n)
    xferTake && xferBad ##1 rejectPulse_q);
  lutReject_c: cover property (@(posedge clock) disable iff (!reset_n)
    bgLutTake && bgLutBad);
  stopRun_c: cover property (@(posedge clock) disable iff (!reset_n)
    stopTake ##1 stop_request_q);

endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`include "image_accel_launch_checker_map.svh"
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import image_accel_launch_checker_pkg::*;

  logic        clock;
  logic        reset_n;
  logic        fgLutLoadReq, bgLutLoadReq, transferReq, stopReq;
  logic        clearBadConfig, fgLutDone, bgLutDone, transferDone;
  convMode_t   conversion_mode;
  lutCfg_t     fgLutCfg, bgLutCfg;
  fgCfg_t      fgCfg;
  bgCfg_t      bgCfg;
  dstCfg_t     dstCfg;
  sizeCfg_t    sizeCfg;
  scaleCfg_t   scaleCfg;
  logic        transfer_go_q, fg_lut_load_go_q, bg_lut_load_go_q;
  logic        stop_request_q, bad_config_flag_q, rejectPulse_q;
  launch_t     launch_q;
  logic [17:0] failedChecks_q;
  logic [2:0]  goBits;
  int          miscompares = 0;
  int          total_checks = 0;

  assign goBits = {fg_lut_load_go_q, bg_lut_load_go_q, transfer_go_q};

  image_accel_launch_checker image_accel_launch_checker_inst (
    .clock(clock), .reset_n(reset_n),
    .fgLutLoadReq(fgLutLoadReq), .bgLutLoadReq(bgLutLoadReq),
    .transferReq(transferReq), .stopReq(stopReq),
    .clearBadConfig(clearBadConfig), .fgLutDone(fgLutDone),
    .bgLutDone(bgLutDone), .transferDone(transferDone),
    .conversion_mode(conversion_mode), .fgLutCfg(fgLutCfg),
    .bgLutCfg(bgLutCfg), .fgCfg(fgCfg), .bgCfg(bgCfg), .dstCfg(dstCfg),
    .sizeCfg(sizeCfg), .scaleCfg(scaleCfg),
    .transfer_go_q(transfer_go_q), .fg_lut_load_go_q(fg_lut_load_go_q),
    .bg_lut_load_go_q(bg_lut_load_go_q), .stop_request_q(stop_request_q),
    .bad_config_flag_q(bad_config_flag_q), .rejectPulse_q(rejectPulse_q),
    .launch_q(launch_q), .failedChecks_q(failedChecks_q)
  );

  always #25 clock = ~clock;

  // inputs move 1 ns after the edge so the design never sees a race
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  // a configuration that passes every check in every mode
  task automatic setBase();
    fgLutCfg = '{32'h0000_5000, 1'b0};
    bgLutCfg = '{32'h0000_6000, 1'b0};
    fgCfg = '{32'h0000_1000, `FMT_ARGB8888, 16'h0, 1'b0, 32'h0};
    bgCfg = '{32'h0000_2000, `FMT_ARGB8888, 16'h0};
    dstCfg = '{32'h0000_3000, `DST_ARGB8888, 16'h0};
    sizeCfg = '{16'h4, 16'h4, 16'h4, 16'h4};
    scaleCfg = '{`SCALE_DEF, `SCALE_DEF, `DEC_DEF, `DEC_DEF, `TURN_DEF};
  endtask

  // op 0 fg LUT, 1 bg LUT, 2 transfer; mask zero means accepted
  task automatic runCase(input int op, input convMode_t mode,
                         input logic [17:0] mask);
    logic [2:0] strobe;
    strobe = 3'b100 >> op;
    conversion_mode = mode;
    {fgLutLoadReq, bgLutLoadReq, transferReq} = strobe;
    tick();
    {fgLutLoadReq, bgLutLoadReq, transferReq} = 3'b000;
    if (mask == 18'h0)
    begin
      `CHK("launch", strobe, launch_q)
      `CHK("go bits", strobe, goBits)
      `CHK("reject", 1'b0, rejectPulse_q)
      tick();
      `CHK("launch end", 3'b000, launch_q)
      {fgLutDone, bgLutDone, transferDone} = strobe;
      tick();
      {fgLutDone, bgLutDone, transferDone} = 3'b000;
      `CHK("go after done", 3'b000, goBits)
    end
    else
    begin
      `CHK("reject", 1'b1, rejectPulse_q)
      `CHK("flag", 1'b1, bad_config_flag_q)
      `CHK("go bits", 3'b000, goBits)
      `CHK("launch", 3'b000, launch_q)
      if (op == 2)
        `CHK("failed checks", mask, failedChecks_q)
      clearBadConfig = 1'b1;
      tick();
      clearBadConfig = 1'b0;
      `CHK("flag cleared", 1'b0, bad_config_flag_q)
      `CHK("reject end", 1'b0, rejectPulse_q)
    end
  endtask

  task automatic testReset();
    repeat (16) @(posedge clock);
    #1;
    `CHK("go at reset", 3'b000, goBits)
    `CHK("launch at reset", 3'b000, launch_q)
    `CHK("stop at reset", 1'b0, stop_request_q)
    `CHK("flag at reset", 1'b0, bad_config_flag_q)
    `CHK("reject at reset", 1'b0, rejectPulse_q)
    `CHK("failed at reset", 18'h0, failedChecks_q)
    reset_n = 1'b1;
    tick();
  endtask

  task automatic testCopy();
    setBase();
    for (int i = 0; i < 16; i++)
    begin
      fgCfg.fmt = 4'(i);
      runCase(2, MODE_COPY, (i > 13) ? 18'h10 : 18'h0);
    end
    setBase();
    fgCfg.base = 32'h0000_1002;
    runCase(2, MODE_COPY, 18'h1);
    fgCfg.fmt = `FMT_RGB565;
    runCase(2, MODE_COPY, 18'h0);
    fgCfg.base = 32'h0000_1001;
    runCase(2, MODE_COPY, 18'h1);
    setBase();
    fgCfg.fmt = `FMT_A4;
    dstCfg.lineGap = 16'h1;
    runCase(2, MODE_COPY, 18'h100);
    runCase(2, MODE_BLEND, 18'h0);
    setBase();
    fgCfg.fmt = `FMT_UYVY422;
    sizeCfg.cols = 16'h3;
    runCase(2, MODE_COPY, 18'h200);
    setBase();
    dstCfg.fmt = 3'h7;
    runCase(2, MODE_COPY, 18'h0);
    setBase();
    fgCfg.fmt = `FMT_YUV420;
    fgCfg.lineGap = 16'h2;
    runCase(2, MODE_COPY, 18'h12);
  endtask

  task automatic testConvert();
    setBase();
    fgCfg.fmt = `FMT_YUV420;
    fgCfg.lineGap = 16'h2;
    runCase(2, MODE_CONVERT, 18'h2);
    fgCfg.lineGap = 16'h0;
    fgCfg.chromaBase = 32'h0000_4001;
    runCase(2, MODE_CONVERT, 18'h8000);
    fgCfg.chromaBase = 32'h0000_4002;
    sizeCfg.cols = 16'h6;
    runCase(2, MODE_CONVERT, 18'h200);
    setBase();
    bgCfg.base = 32'h0000_2002;
    runCase(2, MODE_CONVERT, 18'h0);
    runCase(2, MODE_BLEND, 18'h4);
    setBase();
    scaleCfg.xRecip = 14'h0;
    runCase(2, MODE_CONVERT, 18'h2000);
    scaleCfg.xRecip = 14'h2000;
    runCase(2, MODE_CONVERT, 18'h0);
    scaleCfg.yRecip = 14'h2001;
    runCase(2, MODE_CONVERT, 18'h2000);
    setBase();
    fgCfg.extraPlane = 1'b1;
    fgCfg.fmt = `FMT_YVU420;
    runCase(2, MODE_CONVERT, 18'h4000);
    fgCfg.fmt = `FMT_ARGB8888;
    fgCfg.chromaBase = 32'h0000_4002;
    runCase(2, MODE_CONVERT, 18'h4000);
    fgCfg.fmt = `FMT_RGB565;
    runCase(2, MODE_CONVERT, 18'h0);
    setBase();
    dstCfg.fmt = 3'h5;
    runCase(2, MODE_CONVERT, 18'h40);
  endtask

  task automatic testBlend();
    setBase();
    for (int i = 0; i < 16; i++)
    begin
      bgCfg.fmt = 4'(i);
      runCase(2, MODE_BLEND, (i > 10) ? 18'h20 : 18'h0);
    end
    bgCfg.fmt = `FMT_A4;
    bgCfg.lineGap = 16'h1;
    runCase(2, MODE_BLEND, 18'h8);
    setBase();
    bgCfg.fmt = `FMT_L4;
    sizeCfg.cols = 16'h3;
    runCase(2, MODE_BLEND, 18'h400);
    setBase();
    bgCfg.fmt = `FMT_A4;
    sizeCfg.outCols = 16'h3;
    runCase(2, MODE_BLEND, 18'h0);
    scaleCfg.xRecip = 14'h0800;
    runCase(2, MODE_BLEND, 18'h10000);
    setBase();
    bgCfg.fmt = `FMT_L4;
    scaleCfg.hDec = 2'h1;
    scaleCfg.turn = 2'h1;
    sizeCfg.outRows = 16'h3;
    runCase(2, MODE_BLEND, 18'h20000);
    runCase(2, MODE_CONVERT, 18'h0);
    setBase();
    scaleCfg.xRecip = 14'h2001;
    runCase(2, MODE_BLEND, 18'h2000);
  endtask

  task automatic testFill();
    setBase();
    for (int i = 0; i < 8; i++)
    begin
      dstCfg.fmt = 3'(i);
      runCase(2, MODE_FILL, (i > 4) ? 18'h40 : 18'h0);
    end
    dstCfg.fmt = `DST_RGB565;
    dstCfg.base = 32'h0000_3001;
    runCase(2, MODE_FILL, 18'h80);
    dstCfg.fmt = `DST_ARGB8888;
    dstCfg.base = 32'h0000_3002;
    runCase(2, MODE_FILL, 18'h80);
    setBase();
    sizeCfg.cols = 16'h0;
    sizeCfg.rows = 16'h0;
    runCase(2, MODE_FILL, 18'h1800);
    setBase();
    fgCfg.base = 32'h0000_1001;
    bgCfg.fmt = 4'hF;
    scaleCfg.xRecip = 14'h0;
    runCase(2, MODE_FILL, 18'h0);
  endtask

  task automatic testLut();
    setBase();
    fgLutCfg.base = 32'h0000_5002;
    runCase(0, MODE_FILL, 18'h1);
    fgLutCfg.base = 32'h0000_5001;
    runCase(0, MODE_FILL, 18'h1);
    fgLutCfg.fmtBit = 1'b1;
    runCase(0, MODE_FILL, 18'h0);
    bgLutCfg.base = 32'h0000_6001;
    runCase(1, MODE_COPY, 18'h1);
    bgLutCfg.fmtBit = 1'b1;
    runCase(1, MODE_COPY, 18'h0);
    // a fault and a clear in one cycle must leave the flag set
    fgLutCfg.fmtBit = 1'b0;
    fgLutLoadReq = 1'b1;
    tick();
    `CHK("flag first fault", 1'b1, bad_config_flag_q)
    clearBadConfig = 1'b1;
    tick();
    fgLutLoadReq = 1'b0;
    `CHK("flag set wins", 1'b1, bad_config_flag_q)
    `CHK("second reject", 1'b1, rejectPulse_q)
    tick();
    clearBadConfig = 1'b0;
    `CHK("flag after clear", 1'b0, bad_config_flag_q)
  endtask

  // start is refused while busy; software must stop or wait first
  task automatic testStop();
    setBase();
    {fgLutLoadReq, transferReq} = 2'b11;
    tick();
    {fgLutLoadReq, transferReq} = 2'b00;
    `CHK("priority launch", 3'b100, launch_q)
    transferReq = 1'b1;
    tick();
    transferReq = 1'b0;
    `CHK("busy go", 3'b100, goBits)
    `CHK("busy launch", 3'b000, launch_q)
    stopReq = 1'b1;
    tick();
    stopReq = 1'b0;
    `CHK("stopped go", 3'b000, goBits)
    `CHK("stop pulse", 1'b1, stop_request_q)
    stopReq = 1'b1;
    tick();
    stopReq = 1'b0;
    `CHK("idle stop", 1'b0, stop_request_q)
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #250000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    {fgLutLoadReq, bgLutLoadReq, transferReq, stopReq} = 4'h0;
    {clearBadConfig, fgLutDone, bgLutDone, transferDone} = 4'h0;
    conversion_mode = MODE_COPY;
    setBase();
    testReset();
    testCopy();
    testConvert();
    testBlend();
    testFill();
    testLut();
    testStop();
    wrap_up();
  end
endmodule
`default_nettype wire
